/* File: src/rtcc_top.sv */
// Clock control block: reset pin handling, open-drain interrupt, square wave,
// general RAM with manual clear below the trip point, and host access gating on supply state.
// Assumes all inputs synchronous to clk; supply_ok reports main supply above the trip point.
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/100ps

module rtcc_top
    import rtcc_pkg::*;
#(
    parameter int unsigned OSC_DIV = OSC_DIV_CYCLES
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_we,
    input  wire logic              reg_re,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic              reset_in_n,
    input  wire logic              supply_ok,
    input  wire logic              ram_clear_in_n,
    input  wire logic              alarm_match,
    output logic                   irq_n_o,
    output logic                   irq_n_oe,
    output logic                   square_wave_out,
    output logic                   int_out
);

    // ************************************************************
    // Oscillator tick and divider chain
    // ************************************************************
    localparam int OCW = $clog2(OSC_DIV + 1);

    logic [OCW-1:0]        osc_cnt_q;
    logic                  osc_tick;
    logic [DIV_STAGES-1:0] div_q;
    logic                  update_event;

    assign osc_tick = (osc_cnt_q == OCW'(OSC_DIV - 1));

    // Tick prescaler from the system clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_cnt_q <= '0;
        end else if (osc_tick) begin
            osc_cnt_q <= '0;
        end else begin
            osc_cnt_q <= osc_cnt_q + OCW'(1);
        end
    end

    // Fifteen-stage ripple chain, never touched by the reset pin
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_q <= '0;
        end else if (osc_tick) begin
            div_q <= div_q + DIV_STAGES'(1);
        end
    end

    assign update_event = osc_tick & (&div_q);  // Once-per-second rollover

    // ************************************************************
    // Access gating
    // ************************************************************
    logic access_ok;
    logic wr;
    logic rd;
    logic dev_reset_tick;
    logic in_ram;
    logic [6:0] ram_idx;

    assign access_ok      = reset_in_n & supply_ok;
    assign wr             = reg_we & access_ok;
    assign rd             = reg_re & access_ok;
    assign dev_reset_tick = osc_tick & ~reset_in_n & supply_ok;
    assign in_ram         = (reg_addr >= ADDR_RAM_FIRST);
    assign ram_idx        = reg_addr - ADDR_RAM_FIRST;

    // ************************************************************
    // Control registers
    // ************************************************************
    logic [7:0] ctrl_a_q;
    logic [7:0] ctrl_b_q;
    rtcc_rate_t rate;

    assign rate = ctrl_a_q[3:0];

    // Rate select register, untouched by the reset pin
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_a_q <= CTRL_A_RST;
        end else if (wr && reg_addr == ADDR_CTRL_A) begin
            ctrl_a_q <= reg_wdata;
        end
    end

    // Enable register; reset pin clears enables on each tick while supply_ok is high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_b_q <= CTRL_B_RST;
        end else if (dev_reset_tick) begin
            ctrl_b_q[B_PIE]  <= 1'b0;
            ctrl_b_q[B_AIE]  <= 1'b0;
            ctrl_b_q[B_UIE]  <= 1'b0;
            ctrl_b_q[B_SQUARE_WAVE_ENABLE] <= 1'b0;
        end else if (wr && reg_addr == ADDR_CTRL_B) begin
            ctrl_b_q <= reg_wdata;
        end
    end

    // ************************************************************
    // Divider tap and periodic event
    // ************************************************************
    logic tap_on;
    logic tap_val;
    logic tap_q;
    logic periodic_event;

    assign tap_on         = (rate != RATE_OFF);
    assign tap_val        = tap_on & div_q[rtcc_tap_index(rate)];
    assign periodic_event = tap_val & ~tap_q;

    // Square wave: enable bit, supply state and tap all required
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            square_wave_out <= 1'b0;
        end else begin
            square_wave_out <= ctrl_b_q[B_SQUARE_WAVE_ENABLE] & supply_ok & tap_val;
        end
    end

    // ************************************************************
    // Interrupt flags
    // ************************************************************
    logic pf_q;
    logic af_q;
    logic uf_q;
    logic flags_read;
    logic summary_request_flag;
    logic summary_request_flag_q;

    assign flags_read = rd & (reg_addr == ADDR_FLAGS);

    // Flags: new event beats a clearing read; PF and UF not set under the reset pin while supply_ok is high, AF still set by an alarm match
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pf_q <= 1'b0;
            af_q <= 1'b0;
            uf_q <= 1'b0;
        end else if (dev_reset_tick) begin
            pf_q <= 1'b0;
            uf_q <= 1'b0;
            af_q <= alarm_match | af_q;
        end else begin
            pf_q <= (periodic_event & (reset_in_n | ~supply_ok)) | (pf_q & ~flags_read);
            af_q <= alarm_match | (af_q & ~flags_read);
            uf_q <= (update_event & (reset_in_n | ~supply_ok)) | (uf_q & ~flags_read);
        end
    end

    // Summary flag follows enabled pending flags
    assign summary_request_flag = (pf_q & ctrl_b_q[B_PIE]) | (af_q & ctrl_b_q[B_AIE]) | (uf_q & ctrl_b_q[B_UIE]);

    // Open-drain pin: only ever pulls low
    assign irq_n_o  = 1'b0;
    assign irq_n_oe = summary_request_flag & reset_in_n;

    // ************************************************************
    // General RAM
    // ************************************************************
    logic [7:0] ram_q [RAM_BYTES];
    logic       ram_clr;

    assign ram_clr = ~supply_ok & ~ram_clear_in_n;

    // No reset: contents survive both resets
    always_ff @(posedge clk) begin
        if (ram_clr) begin
            for (int i = 0; i < RAM_BYTES; i++) begin
                ram_q[i] <= RAM_CLEAR;
            end
        end else if (wr && in_ram) begin
            ram_q[ram_idx] <= reg_wdata;
        end
    end

    // ************************************************************
    // System event status and mask
    // ************************************************************
    logic [S_W-1:0] sys_stat_q;
    logic [S_W-1:0] sys_mask_q;
    logic [S_W-1:0] sys_ev;
    logic [S_W-1:0] sys_clr;
    logic           supply_q;
    logic           ram_clr_q;

    assign sys_ev[S_IRQ]   = summary_request_flag & ~summary_request_flag_q;
    assign sys_ev[S_PFAIL] = supply_q & ~supply_ok;
    assign sys_ev[S_RAM_CLEAR_IN]  = ram_clr & ~ram_clr_q;
    assign sys_clr         = (wr && reg_addr == ADDR_SYS_STAT) ? reg_wdata[S_W-1:0] : '0;

    // Edge history for the event detectors
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            summary_request_flag_q    <= 1'b0;
            tap_q     <= 1'b0;
            supply_q  <= 1'b0;
            ram_clr_q <= 1'b0;
        end else begin
            summary_request_flag_q    <= summary_request_flag;
            tap_q     <= tap_val;
            supply_q  <= supply_ok;
            ram_clr_q <= ram_clr;
        end
    end

    // Sticky status, write one to clear, set wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sys_stat_q <= SYS_RST;
        end else begin
            sys_stat_q <= sys_ev | (sys_stat_q & ~sys_clr);
        end
    end

    // Mask register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sys_mask_q <= SYS_RST;
        end else if (wr && reg_addr == ADDR_SYS_MASK) begin
            sys_mask_q <= reg_wdata[S_W-1:0];
        end
    end

    assign int_out = |(sys_stat_q & sys_mask_q);

    // ************************************************************
    // Read data
    // ************************************************************
    logic [7:0] rd_mux;

    // Read multiplexer; unmapped bytes read zero
    always_comb begin
        rd_mux = 8'h00;
        if (in_ram) begin
            rd_mux = ram_q[ram_idx];
        end else if (reg_addr == ADDR_CTRL_A) begin
            rd_mux = ctrl_a_q;
        end else if (reg_addr == ADDR_CTRL_B) begin
            rd_mux = ctrl_b_q;
        end else if (reg_addr == ADDR_FLAGS) begin
            rd_mux = {summary_request_flag, pf_q, af_q, uf_q, 4'h0};
        end else if (reg_addr == ADDR_SYS_STAT) begin
            rd_mux = {5'h00, sys_stat_q};
        end else if (reg_addr == ADDR_SYS_MASK) begin
            rd_mux = {5'h00, sys_mask_q};
        end
    end

    // Data valid only in the cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= rd ? rd_mux : 8'h00;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_rst_enables;
        @(posedge clk) disable iff (rst)
        dev_reset_tick |=> !ctrl_b_q[B_PIE] && !ctrl_b_q[B_AIE] && !ctrl_b_q[B_UIE];
    endproperty
    a_rst_enables: assert property (p_rst_enables)
        else $error("interrupt enables not cleared by reset pin");
    property p_rst_flags;
        @(posedge clk) disable iff (rst)
        dev_reset_tick |=> !pf_q && !uf_q && !summary_request_flag;
    endproperty
    a_rst_flags: assert property (p_rst_flags)
        else $error("flags not cleared by reset pin");
    property p_rst_square_wave_enable;
        @(posedge clk) disable iff (rst)
        dev_reset_tick |=> !ctrl_b_q[B_SQUARE_WAVE_ENABLE] ##1 !square_wave_out;
    endproperty
    a_rst_square_wave_enable: assert property (p_rst_square_wave_enable)
        else $error("square wave enable not cleared by reset pin");
    property p_irq_hiz;
        @(posedge clk) disable iff (rst)
        !reset_in_n |-> !irq_n_oe;
    endproperty
    a_irq_hiz: assert property (p_irq_hiz)
        else $error("interrupt pin driven during reset");
    property p_no_access;
        @(posedge clk) disable iff (rst)
        (reg_we && !reset_in_n) |=> $stable(ctrl_a_q) && $stable(sys_mask_q);
    endproperty
    a_no_access: assert property (p_no_access)
        else $error("write accepted while reset pin low");
    property p_ram_kept;
        @(posedge clk) disable iff (rst)
        (!reset_in_n && supply_ok) |=> $stable(ram_q[0]);
    endproperty
    a_ram_kept: assert property (p_ram_kept)
        else $error("RAM changed during reset pin");
    property p_irq_drive;
        @(posedge clk) disable iff (rst)
        (reset_in_n && pf_q && ctrl_b_q[B_PIE]) |-> irq_n_oe && !irq_n_o;
    endproperty
    a_irq_drive: assert property (p_irq_drive)
        else $error("interrupt pin not pulled low");

    property p_read_clears;
        @(posedge clk) disable iff (rst)
        (flags_read && !periodic_event && !update_event && !alarm_match) |=> !pf_q && !uf_q && !af_q && !irq_n_oe;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("flag read did not clear flags");

    property p_ram_clear;
        @(posedge clk) disable iff (rst)
        ram_clr |=> ram_q[RAM_BYTES-1] == RAM_CLEAR && ram_q[0] == RAM_CLEAR;
    endproperty
    a_ram_clear: assert property (p_ram_clear)
        else $error("RAM not set to ones");

    property p_tap;
        @(posedge clk) disable iff (rst)
        (supply_ok && ctrl_b_q[B_SQUARE_WAVE_ENABLE] && rate == 4'h3) |=> square_wave_out == $past(div_q[1]);
    endproperty
    a_tap: assert property (p_tap)
        else $error("square wave tap mismatch");

    property p_sqw_off;
        @(posedge clk) disable iff (rst)
        (!ctrl_b_q[B_SQUARE_WAVE_ENABLE] || !supply_ok) |=> !square_wave_out;
    endproperty
    a_sqw_off: assert property (p_sqw_off)
        else $error("square wave active while disabled");

    property p_pfail_block;
        @(posedge clk) disable iff (rst)
        (reg_re && !supply_ok) |=> reg_rdata == 8'h00;
    endproperty
    a_pfail_block: assert property (p_pfail_block)
        else $error("read served below trip point");

endmodule

/* File: src/rtcc_pkg.sv */
// Package for the clock control block: offsets, bit positions, reset values, counts.
// Assumes an 8-bit register port with a 7-bit byte address and a 250 MHz system clock.
package rtcc_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ         = 250_000_000;
    localparam int OSC_HZ         = 32_768;
    localparam int OSC_DIV_CYCLES = CLK_HZ / OSC_HZ;  // System cycles per oscillator tick
    localparam int DIV_STAGES     = 15;               // Divider stages below the 1 Hz carry

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int        ADDR_W         = 7;
    localparam int        DATA_W         = 8;
    localparam bit [6:0]  ADDR_SYS_STAT  = 7'h08;
    localparam bit [6:0]  ADDR_SYS_MASK  = 7'h09;
    localparam bit [6:0]  ADDR_CTRL_A    = 7'h0A;
    localparam bit [6:0]  ADDR_CTRL_B    = 7'h0B;
    localparam bit [6:0]  ADDR_FLAGS     = 7'h0C;
    localparam bit [6:0]  ADDR_RAM_FIRST = 7'h0E;
    localparam int        RAM_BYTES      = 114;

    // Control B fields
    localparam int B_PIE  = 6;
    localparam int B_AIE  = 5;
    localparam int B_UIE  = 4;
    localparam int B_SQUARE_WAVE_ENABLE = 3;

    // Flag register fields
    localparam int F_SUMMARY_REQUEST_FLAG = 7;
    localparam int F_PF   = 6;
    localparam int F_AF   = 5;
    localparam int F_UF   = 4;

    // System event status fields
    localparam int S_IRQ   = 0;
    localparam int S_PFAIL = 1;
    localparam int S_RAM_CLEAR_IN  = 2;
    localparam int S_W     = 3;

    // Reset values
    localparam bit [7:0] CTRL_A_RST = 8'h00;
    localparam bit [7:0] CTRL_B_RST = 8'h00;
    localparam bit [2:0] SYS_RST    = 3'h0;
    localparam bit [7:0] RAM_CLEAR  = 8'hFF;

    // Rate select codes
    localparam bit [3:0] RATE_OFF  = 4'h0;
    localparam bit [3:0] RATE_256  = 4'h1;
    localparam bit [3:0] RATE_128  = 4'h2;
    localparam bit [3:0] TAP_256   = 4'h6;
    localparam bit [3:0] TAP_128   = 4'h7;
    localparam bit [3:0] TAP_SHIFT = 4'h2;

    typedef logic [3:0] rtcc_rate_t;

    // Divider stage picked by a rate code
    function automatic logic [3:0] rtcc_tap_index(input rtcc_rate_t rate);
        logic [3:0] idx;
        idx = 4'h0;
        unique case (rate)
            RATE_256: idx = TAP_256;
            RATE_128: idx = TAP_128;
            default:  idx = rate - TAP_SHIFT;
        endcase
        return idx;
    endfunction

endpackage

/* File: bench/rtcc_host_model.sv */
// Host side model: register port master and the pulled-up interrupt line.
// Assumes the block's one-cycle strobes and read data one cycle after the read strobe.
`timescale 1ns/100ps

module rtcc_host_model
    import rtcc_pkg::*;
(
    input  wire logic              clk,
    output logic      [ADDR_W-1:0] reg_addr,
    output logic      [DATA_W-1:0] reg_wdata,
    output logic                   reg_we,
    output logic                   reg_re,
    input  wire logic [DATA_W-1:0] reg_rdata,
    input  wire logic              irq_n_o,
    input  wire logic              irq_n_oe,
    output logic                   irq_line
);
    // ************************************************************
    // Shared interrupt line
    // ************************************************************
    // External pull-up wins while the pin is released
    assign irq_line = irq_n_oe ? irq_n_o : 1'b1;

    // Idle bus at time zero
    initial begin
        reg_addr  <= '0;
        reg_wdata <= '0;
        reg_we    <= 1'b0;
        reg_re    <= 1'b0;
    end

    // ************************************************************
    // Bus cycles
    // ************************************************************
    // One-cycle write strobe
    task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_we    <= 1'b1;
        @(posedge clk);
        reg_we    <= 1'b0;
        reg_wdata <= ~d;  // Stale data not left showing
    endtask

    // One-cycle read strobe, data taken at the following edge
    task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_re   <= 1'b1;
        @(posedge clk);
        reg_re   <= 1'b0;
        @(posedge clk);
        d = reg_rdata;  // Flag register read acknowledges interrupts
    endtask
endmodule

/* File: bench/tb.sv */
// Testbench for the clock control block: register tasks through the host model.
// Assumes the divider tick shortened to 4 system cycles.
`timescale 1ns/100ps

module tb
    import rtcc_pkg::*;
;
    localparam int OSCD = 4;

    logic              clk;
    logic              rst;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic              reg_we;
    logic              reg_re;
    logic [DATA_W-1:0] reg_rdata;
    logic              reset_in_n;
    logic              supply_ok;
    logic              ram_clear_in_n;
    logic              alarm_match;
    logic              irq_n_o;
    logic              irq_n_oe;
    logic              irq_line;
    logic              square_wave_out;
    logic              int_out;
    int                mismatches;
    int                num_checks;

    rtcc_top #(.OSC_DIV(OSCD)) rtcc_top_inst (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re), .reg_rdata(reg_rdata), .reset_in_n(reset_in_n), .supply_ok(supply_ok),
        .ram_clear_in_n(ram_clear_in_n), .alarm_match(alarm_match), .irq_n_o(irq_n_o),
        .irq_n_oe(irq_n_oe), .square_wave_out(square_wave_out), .int_out(int_out)
    );

    rtcc_host_model rtcc_host_model_inst (
        .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(reg_rdata), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .irq_line(irq_line)
    );

    // ************************************************************
    // Helpers
    // ************************************************************
    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Register read and compare
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        rtcc_host_model_inst.reg_read(a, d);
        chk(d, exp, what);
    endtask

    // Register write
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        rtcc_host_model_inst.reg_write(a, d);
    endtask

    // Rising edges of the square wave over n cycles
    task automatic count_sq(input int n, output int c);
        logic prev;
        c = 0;
        repeat (2) @(posedge clk);  // Let the last register write reach the output
        prev = square_wave_out;
        repeat (n) begin
            @(posedge clk);
            if (square_wave_out === 1'b1 && prev === 1'b0) c++;
            prev = square_wave_out;
        end
    endtask

    // Verdict and end of run
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Run limit
    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        $display("CHECK FAILED t=%0t run limit reached", $time);
        complete_run();
    end

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        int c;
        int tap;
        rst <= 1'b1;
        reset_in_n <= 1'b1;
        supply_ok <= 1'b1;
        ram_clear_in_n <= 1'b1;
        alarm_match <= 1'b0;
        mismatches = 0;
        num_checks = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;

        // Alarm interrupt, flag read, pin release
        wr(ADDR_CTRL_B, 8'h78);
        wr(ADDR_SYS_MASK, 8'h07);
        rd_chk(ADDR_CTRL_B, 8'h78, "ctrl b readback");
        @(posedge clk);
        alarm_match <= 1'b1;
        @(posedge clk);
        alarm_match <= 1'b0;
        @(posedge clk);
        #1;
        chk({7'h00, irq_line}, 8'h00, "irq asserted");
        rd_chk(ADDR_FLAGS, 8'hA0, "flags alarm");
        #1;
        chk({7'h00, irq_line}, 8'h01, "irq released");
        rd_chk(ADDR_FLAGS, 8'h00, "flags cleared");
        rd_chk(ADDR_SYS_STAT, 8'h01, "event status irq");
        $display("test alarm irq done");

        // Square wave rates
        for (int code = 0; code < 6; code++) begin
            wr(ADDR_CTRL_A, 8'(code));
            tap = (code == 1) ? 6 : (code == 2) ? 7 : code - 2;
            count_sq((code == 0) ? 512 : (8 * OSCD) << (tap + 1), c);
            chk(8'((code == 0) ? (c == 0) : (c >= 7 && c <= 9)), 8'h01, "square wave rate");
        end
        wr(ADDR_CTRL_A, 8'h03);
        wr(ADDR_CTRL_B, 8'h00);
        count_sq(64, c);
        chk(8'(c), 8'h00, "square wave disabled");
        $display("test square wave done");

        // Backup mode: access block, RAM clear, event status
        wr(ADDR_CTRL_B, 8'h08);
        wr(ADDR_RAM_FIRST, 8'h12);
        wr(7'h7F, 8'h34);
        wr(7'h0D, 8'h55);
        rd_chk(7'h0D, 8'h00, "unmapped read");
        rd_chk(7'h00, 8'h00, "unmapped read");
        wr(ADDR_SYS_STAT, 8'h07);
        @(posedge clk);
        supply_ok <= 1'b0;
        count_sq(64, c);
        chk(8'(c), 8'h00, "square wave in backup");
        rd_chk(ADDR_CTRL_B, 8'h00, "read blocked in backup");
        wr(ADDR_CTRL_A, 8'h05);
        ram_clear_in_n <= 1'b0;
        repeat (3) @(posedge clk);
        ram_clear_in_n <= 1'b1;
        supply_ok <= 1'b1;
        rd_chk(ADDR_CTRL_A, 8'h03, "write blocked in backup");
        rd_chk(ADDR_CTRL_B, 8'h08, "control kept by ram clear");
        rd_chk(ADDR_RAM_FIRST, 8'hFF, "ram first cleared");
        rd_chk(7'h7F, 8'hFF, "ram last cleared");
        rd_chk(ADDR_SYS_STAT, 8'h06, "event status");
        #1;
        chk({7'h00, int_out}, 8'h01, "int out set");
        wr(ADDR_SYS_MASK, 8'h00);
        #1;
        chk({7'h00, int_out}, 8'h00, "int out masked");
        wr(ADDR_SYS_MASK, 8'h07);
        wr(ADDR_SYS_STAT, 8'h06);
        #1;
        chk({7'h00, int_out}, 8'h00, "int out cleared");
        $display("test backup done");

        // Reset pin
        wr(7'h20, 8'h5A);
        wr(ADDR_CTRL_B, 8'h78);
        wr(ADDR_CTRL_A, 8'h03);
        repeat (64) @(posedge clk);
        wr(ADDR_CTRL_A, 8'h00);
        #1;
        chk({7'h00, irq_line}, 8'h00, "periodic irq");
        @(posedge clk);
        reset_in_n <= 1'b0;
        @(posedge clk);
        #1;
        chk({7'h00, irq_line}, 8'h01, "irq released in reset");
        wr(ADDR_CTRL_A, 8'h07);
        rd_chk(ADDR_CTRL_B, 8'h00, "read refused in reset");
        repeat (4 * OSCD) @(posedge clk);
        reset_in_n <= 1'b1;
        rd_chk(ADDR_CTRL_B, 8'h00, "enables cleared");
        rd_chk(ADDR_FLAGS, 8'h00, "flags cleared by reset");
        rd_chk(ADDR_CTRL_A, 8'h00, "write refused in reset");
        rd_chk(7'h20, 8'h5A, "ram kept");
        $display("test reset pin done");
        complete_run();
    end
endmodule
